// [verilog/fba_core.sv]
/*
  Flag-test transfers, index-count jumps and effective address forming
  with indirect, indexed, halfword and immediate modifiers, plus an APB
  register slave. Assumes core memory answers a held mem_req with a one
  cycle mem_ack, and the index file answers idx_rsel combinationally.
*/
`timescale 1ns/100ps
`include "fba_params.svh"

// Summary of operation
// - Sixteen-bit condition register holds testable flags
// - Software may write condition bits directly
// - Arithmetic completion updates zero, positive, negative
// - Four-bit selector picks one of sixteen conditions
// - Inverted option tests the complemented condition
// - Halt, then branch when condition holds
// - Execute remote instruction when condition holds
// - Call subroutine on condition; variant clears flag
// - Branches conditional; variants clear, set, toggle
// - Flag modification happens whatever the test gives
// - Index jump counts then branches on signs
// - Instruction is 32 bits: operation and address
// - Indirect fetch replaces address, repeatable levels
// - Indexing adds index register to address field
// - Index class never applies indexing
// - Halfword selector picks left or right half
// - Halfword selector leaves addressing untouched
// - Immediate operand comes from effective address
// - Immediate only for 16-bit non-store, no halfword
// - Overflow accumulates; other arithmetic flags refresh
module fba_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [14:0] instr_pc,
  output logic instr_ready,
  output logic mem_req,
  output logic [14:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [2:0] idx_rsel,
  input wire logic [15:0] idx_rdata,
  output logic idx_we,
  output logic [2:0] idx_wsel,
  output logic [15:0] idx_wdata,
  input wire logic arith_done,
  input wire logic acc_zero,
  input wire logic acc_pos,
  input wire logic acc_neg,
  input wire logic arith_ovf,
  input wire logic arith_carry,
  input wire logic chan_busy,
  input wire logic int_mode,
  output logic xfer_pulse,
  output logic [14:0] xfer_addr,
  output logic link_pulse,
  output logic [14:0] link_addr,
  output logic exec_pulse,
  output logic [14:0] exec_addr,
  output logic halted,
  output logic operand_valid,
  output logic [31:0] operand_data,
  output logic store_req,
  output logic [14:0] eff_addr,
  output logic illegal,
  output logic [15:0] flags
);
  import fba_pkg::*;

  function automatic logic is_indexable(input fba_class_t c);
    return (c != FBA_CLS_INDEX) && (c != FBA_CLS_XJUMP);
  endfunction

  function automatic logic needs_fetch(input fba_class_t c,
                                       input logic imm);
    return ((c == FBA_CLS_OP16) || (c == FBA_CLS_INDEX)) ? !imm :
           (c == FBA_CLS_OP32);
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == `FBA_OFS_FLAGS) || (a == `FBA_OFS_STATUS) ||
           (a == `FBA_OFS_CTRL) || (a == `FBA_OFS_LASTEA);
  endfunction

  fba_state_t state_q;
  logic [31:0] ir_q;
  logic [14:0] pc_q;
  logic [14:0] addr_q;
  logic ind_q;
  logic [2:0] xsel_q;
  logic [14:0] ea_q;
  logic halted_q;
  logic illegal_q;
  logic mem_req_q;
  logic [14:0] mem_addr_q;
  logic [31:0] operand_q;
  logic operand_valid_q;
  logic store_req_q;
  logic xfer_q;
  logic [14:0] xfer_addr_q;
  logic link_q;
  logic [14:0] link_addr_q;
  logic exec_q;
  logic [14:0] exec_addr_q;
  logic idx_we_q;
  logic [2:0] idx_wsel_q;
  logic [15:0] idx_wdata_q;
  logic [31:0] prdata_q;
  logic perr_q;

  fba_class_t cls;
  fba_flag_op_t fop;
  logic [3:0] fsel;
  logic [2:0] tgt;
  logic imm;
  logic half;
  logic cond;
  logic bad_mode;
  logic [14:0] ea;
  logic [3:0] cnt;
  logic [15:0] xnew;
  logic xjump_take;
  logic apb_setup;
  logic apb_wr;
  logic sw_we;
  logic resume;
  logic clr_err;
  logic mod_en;
  fba_mod_t mod_op;

  assign cls = fba_class_t'(ir_q[`FBA_CLS_HI:`FBA_CLS_LO]);
  assign fop = fba_flag_op_t'(ir_q[`FBA_SUB_HI:`FBA_SUB_LO]);
  assign fsel = ir_q[`FBA_FSEL_HI:`FBA_FSEL_LO];
  assign tgt = ir_q[`FBA_XSEL_HI:`FBA_XSEL_LO];
  assign imm = ir_q[`FBA_IMM_BIT];
  assign half = ir_q[`FBA_HALF_BIT];
  assign cnt = fsel;

  // flags_q is the pre-update value, so any modify this cycle is unseen
  assign cond = flags[fsel] ^ ir_q[`FBA_INV_BIT];

  // immediate is a 16-bit, non-store operand with no halfword selector
  assign bad_mode = imm && (half || !((cls == FBA_CLS_OP16) ||
                    (cls == FBA_CLS_INDEX)));

  // the halfword bit is not consulted on the address path at all
  assign ea = addr_q + ((xsel_q != 3'h0 && is_indexable(cls)) ?
              idx_rdata[14:0] : 15'h0000);

  // counting and index-class instructions read their own target register
  assign idx_rsel = is_indexable(cls) ? xsel_q : tgt;

  // branch while the count has not carried the index past zero
  assign xnew = idx_rdata + {{12{cnt[3]}}, cnt};
  assign xjump_take = cnt[3] != xnew[15];

  always_comb begin
    mod_en = 1'b0;
    mod_op = FBA_MOD_NONE;
    if (state_q == FBA_S_EXEC && cls == FBA_CLS_FLAG) begin
      case (fop)
        call_clear_flag,
        branch_clear_flag: begin
          mod_en = 1'b1;
          mod_op = FBA_MOD_CLEAR;
        end
        branch_raise_flag: begin
          mod_en = 1'b1;
          mod_op = FBA_MOD_SET;
        end
        branch_toggle_flag: begin
          mod_en = 1'b1;
          mod_op = FBA_MOD_TOGGLE;
        end
        default: mod_en = 1'b0;
      endcase
    end
  end

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign sw_we = apb_wr && paddr == `FBA_OFS_FLAGS;
  assign resume = apb_wr && paddr == `FBA_OFS_CTRL &&
                  pwdata[`FBA_CTRL_RESUME];
  assign clr_err = apb_wr && paddr == `FBA_OFS_CTRL &&
                   pwdata[`FBA_CTRL_CLRERR];

  fba_cond_reg u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .arith_done(arith_done),
    .acc_zero(acc_zero),
    .acc_pos(acc_pos),
    .acc_neg(acc_neg),
    .arith_ovf(arith_ovf),
    .arith_carry(arith_carry),
    .chan_busy(chan_busy),
    .int_mode(int_mode),
    .sw_we(sw_we),
    .sw_wdata(pwdata[15:0]),
    .mod_en(mod_en),
    .mod_sel(fsel),
    .mod_op(mod_op),
    .flags(flags)
  );

  // sequencer: accept, form address, chase indirection, fetch, execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FBA_S_IDLE;
      ir_q <= 32'h00000000;
      pc_q <= 15'h0000;
      addr_q <= 15'h0000;
      ind_q <= 1'b0;
      xsel_q <= 3'h0;
      ea_q <= 15'h0000;
      halted_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_addr_q <= 15'h0000;
      operand_q <= 32'h00000000;
    end else begin
      case (state_q)
        FBA_S_IDLE: begin
          if (instr_valid) begin
            ir_q <= instr_word;
            pc_q <= instr_pc;
            addr_q <= instr_word[`FBA_ADR_HI:0];
            ind_q <= instr_word[`FBA_IND_BIT];
            xsel_q <= instr_word[`FBA_XSEL_HI:`FBA_XSEL_LO];
            state_q <= FBA_S_ADDR;
          end
        end
        FBA_S_ADDR: begin
          ea_q <= ea;
          if (bad_mode) begin
            state_q <= FBA_S_IDLE;
          end else if (ind_q) begin
            mem_req_q <= 1'b1;
            mem_addr_q <= ea;
            state_q <= FBA_S_IND;
          end else if (needs_fetch(cls, imm)) begin
            mem_req_q <= 1'b1;
            mem_addr_q <= ea;
            state_q <= FBA_S_OPND;
          end else begin
            operand_q <= {17'h00000, ea};
            state_q <= FBA_S_EXEC;
          end
        end
        FBA_S_IND: begin
          if (mem_ack) begin
            // fetched word supplies the next level's address modifiers
            mem_req_q <= 1'b0;
            addr_q <= mem_rdata[`FBA_ADR_HI:0];
            ind_q <= mem_rdata[`FBA_IND_BIT];
            xsel_q <= mem_rdata[`FBA_XSEL_HI:`FBA_XSEL_LO];
            state_q <= FBA_S_ADDR;
          end
        end
        FBA_S_OPND: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            if (cls == FBA_CLS_OP32) begin
              operand_q <= mem_rdata;
            end else if (half) begin
              operand_q <= {16'h0000, mem_rdata[15:0]};
            end else begin
              operand_q <= {16'h0000, mem_rdata[31:16]};
            end
            state_q <= FBA_S_EXEC;
          end
        end
        FBA_S_EXEC: begin
          if (cls == FBA_CLS_FLAG && fop == halt_then_branch && cond) begin
            halted_q <= 1'b1;
            state_q <= FBA_S_HALT;
          end else begin
            state_q <= FBA_S_IDLE;
          end
        end
        FBA_S_HALT: begin
          if (resume) begin
            halted_q <= 1'b0;
            state_q <= FBA_S_IDLE;
          end
        end
        default: state_q <= FBA_S_IDLE;
      endcase
    end
  end

  // one-cycle transfer, call, execute, operand and index-write strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_q <= 1'b0;
      xfer_addr_q <= 15'h0000;
      link_q <= 1'b0;
      link_addr_q <= 15'h0000;
      exec_q <= 1'b0;
      exec_addr_q <= 15'h0000;
      operand_valid_q <= 1'b0;
      store_req_q <= 1'b0;
      idx_we_q <= 1'b0;
      idx_wsel_q <= 3'h0;
      idx_wdata_q <= 16'h0000;
    end else begin
      xfer_q <= 1'b0;
      link_q <= 1'b0;
      exec_q <= 1'b0;
      operand_valid_q <= 1'b0;
      store_req_q <= 1'b0;
      idx_we_q <= 1'b0;
      if (state_q == FBA_S_HALT && resume) begin
        xfer_q <= 1'b1;
        xfer_addr_q <= ea_q;
      end else if (state_q == FBA_S_EXEC) begin
        case (cls)
          FBA_CLS_FLAG: begin
            if (cond && fop == remote_execute) begin
              exec_q <= 1'b1;
              exec_addr_q <= ea_q;
            end else if (cond && (fop == cond_call ||
                         fop == call_clear_flag)) begin
              link_q <= 1'b1;
              link_addr_q <= 15'(pc_q + 15'h0001);
              xfer_q <= 1'b1;
              xfer_addr_q <= ea_q;
            end else if (cond && fop != halt_then_branch) begin
              xfer_q <= 1'b1;
              xfer_addr_q <= ea_q;
            end
          end
          FBA_CLS_XJUMP: begin
            idx_we_q <= 1'b1;
            idx_wsel_q <= tgt;
            idx_wdata_q <= xnew;
            xfer_q <= xjump_take;
            xfer_addr_q <= ea_q;
          end
          FBA_CLS_INDEX: begin
            idx_we_q <= 1'b1;
            idx_wsel_q <= tgt;
            idx_wdata_q <= operand_q[15:0];
          end
          FBA_CLS_STORE16: store_req_q <= 1'b1;
          FBA_CLS_OP16,
          FBA_CLS_OP32: operand_valid_q <= 1'b1;
          default: operand_valid_q <= 1'b0;
        endcase
      end
    end
  end

  // sticky modifier error; a new fault beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_q <= 1'b0;
    end else if (state_q == FBA_S_ADDR && bad_mode) begin
      illegal_q <= 1'b1;
    end else if (clr_err) begin
      illegal_q <= 1'b0;
    end
  end

  // read data captured in the setup phase, so every access is zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      perr_q <= 1'b0;
    end else if (apb_setup) begin
      perr_q <= !reg_hit(paddr);
      case (paddr)
        `FBA_OFS_FLAGS: prdata_q <= {16'h0000, flags};
        `FBA_OFS_STATUS: prdata_q <= {30'h00000000, illegal_q, halted_q};
        `FBA_OFS_LASTEA: prdata_q <= {17'h00000, ea_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && perr_q;

  assign instr_ready = state_q == FBA_S_IDLE;
  assign mem_req = mem_req_q;
  assign mem_addr = mem_addr_q;
  assign idx_we = idx_we_q;
  assign idx_wsel = idx_wsel_q;
  assign idx_wdata = idx_wdata_q;
  assign xfer_pulse = xfer_q;
  assign xfer_addr = xfer_addr_q;
  assign link_pulse = link_q;
  assign link_addr = link_addr_q;
  assign exec_pulse = exec_q;
  assign exec_addr = exec_addr_q;
  assign halted = halted_q;
  assign operand_valid = operand_valid_q;
  assign operand_data = operand_q;
  assign store_req = store_req_q;
  assign eff_addr = ea_q;
  assign illegal = illegal_q;

endmodule

// [verilog/fba_params.svh]
/*
  Constants for the flag, branch and address-mode block: instruction
  field positions, register offsets, condition bit positions and resets.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef FBA_PARAMS_SVH
`define FBA_PARAMS_SVH

`define FBA_ADDR_W 15
`define FBA_CLS_HI 31
`define FBA_CLS_LO 29
`define FBA_SUB_HI 28
`define FBA_SUB_LO 26
`define FBA_INV_BIT 25
`define FBA_FSEL_HI 24
`define FBA_FSEL_LO 21
`define FBA_IND_BIT 20
`define FBA_IMM_BIT 19
`define FBA_HALF_BIT 18
`define FBA_XSEL_HI 17
`define FBA_XSEL_LO 15
`define FBA_ADR_HI 14

`define FBA_OFS_FLAGS 8'h00
`define FBA_OFS_STATUS 8'h04
`define FBA_OFS_CTRL 8'h08
`define FBA_OFS_LASTEA 8'h0C

`define FBA_CTRL_RESUME 0
`define FBA_CTRL_CLRERR 1

`define FBA_F_ONE 0
`define FBA_F_ZERO 1
`define FBA_F_POS 2
`define FBA_F_NEG 3
`define FBA_F_OVF 4
`define FBA_F_CARRY 5
`define FBA_F_BUSY 6
`define FBA_F_INTEN 7

`define FBA_FLAGS_RST 16'h0001

`endif

// [verilog/fba_pkg.sv]
/*
  Types for the flag, branch and address-mode block.
  Assumes the constants header is on the include path.
*/
`include "fba_params.svh"

package fba_pkg;

  typedef enum logic [2:0] {
    FBA_CLS_FLAG,
    FBA_CLS_XJUMP,
    FBA_CLS_OP16,
    FBA_CLS_STORE16,
    FBA_CLS_OP32,
    FBA_CLS_INDEX,
    FBA_CLS_RSV6,
    FBA_CLS_RSV7
  } fba_class_t;

  typedef enum logic [2:0] {
    halt_then_branch,
    remote_execute,
    cond_call,
    call_clear_flag,
    cond_branch,
    branch_clear_flag,
    branch_raise_flag,
    branch_toggle_flag
  } fba_flag_op_t;

  typedef enum logic [1:0] {
    FBA_MOD_NONE,
    FBA_MOD_CLEAR,
    FBA_MOD_SET,
    FBA_MOD_TOGGLE
  } fba_mod_t;

  typedef enum logic [2:0] {
    FBA_S_IDLE,
    FBA_S_ADDR,
    FBA_S_IND,
    FBA_S_OPND,
    FBA_S_EXEC,
    FBA_S_HALT
  } fba_state_t;

endpackage

// [verilog/fba_cond_reg.sv]
/*
  Sixteen-bit condition register with automatic arithmetic update,
  software write and single-bit set, clear or toggle.
  Assumes all inputs synchronous to pclk; the update pulses are one cycle.
*/
`timescale 1ns/100ps
`include "fba_params.svh"

module fba_cond_reg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arith_done,
  input wire logic acc_zero,
  input wire logic acc_pos,
  input wire logic acc_neg,
  input wire logic arith_ovf,
  input wire logic arith_carry,
  input wire logic chan_busy,
  input wire logic int_mode,
  input wire logic sw_we,
  input wire logic [15:0] sw_wdata,
  input wire logic mod_en,
  input wire logic [3:0] mod_sel,
  input wire fba_pkg::fba_mod_t mod_op,
  output logic [15:0] flags
);
  import fba_pkg::*;

  logic [15:0] flags_q;
  logic [15:0] flags_d;

  always_comb begin
    flags_d = flags_q;
    if (sw_we) begin
      flags_d = sw_wdata;
    end
    if (mod_en) begin
      case (mod_op)
        FBA_MOD_CLEAR: flags_d[mod_sel] = 1'b0;
        FBA_MOD_SET: flags_d[mod_sel] = 1'b1;
        FBA_MOD_TOGGLE: flags_d[mod_sel] = ~flags_q[mod_sel];
        default: flags_d = flags_d;
      endcase
    end
    if (arith_done) begin
      flags_d[`FBA_F_ZERO] = acc_zero;
      flags_d[`FBA_F_POS] = acc_pos;
      flags_d[`FBA_F_NEG] = acc_neg;
      flags_d[`FBA_F_CARRY] = arith_carry;
      // overflow only ever sets here; a clear in the same cycle loses
      if (arith_ovf) begin
        flags_d[`FBA_F_OVF] = 1'b1;
      end
    end
    // status-driven bits follow their sources, software cannot hold them
    flags_d[`FBA_F_ONE] = 1'b1;
    flags_d[`FBA_F_BUSY] = chan_busy;
    flags_d[`FBA_F_INTEN] = int_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `FBA_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

// [testbench/fba_props.sv]
/*
  Checker bound to the core's ports.
  Assumes one pclk domain, presetn async.
*/
`timescale 1ns/100ps

module fba_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic instr_ready,
  input wire logic mem_req,
  input wire logic idx_we,
  input wire logic [2:0] idx_wsel,
  input wire logic arith_done,
  input wire logic acc_zero,
  input wire logic acc_neg,
  input wire logic arith_ovf,
  input wire logic chan_busy,
  input wire logic xfer_pulse,
  input wire logic [14:0] xfer_addr,
  input wire logic link_pulse,
  input wire logic halted,
  input wire logic illegal,
  input wire logic [15:0] flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic take = instr_valid && instr_ready;
  wire logic wr = psel && penable && pwrite;

  chk_always_one: assert property (flags[0])
    else $error("flag 0 low");
  chk_busy_track: assert property (flags[6] == $past(chan_busy))
    else $error("busy flag stale");
  chk_arith_update: assert property (arith_done && !wr && instr_ready
    |=> flags[1] == $past(acc_zero) && flags[3] == $past(acc_neg))
    else $error("arith flags stale");
  chk_ovf_sticky: assert property (arith_done && arith_ovf |=> flags[4])
    else $error("overflow lost");
  chk_ovf_hold: assert property ($fell(flags[4])
    |-> $past(wr) || $past(!instr_ready))
    else $error("overflow dropped");
  chk_call_pair: assert property (link_pulse |-> xfer_pulse)
    else $error("lone link");
  chk_branch_lat: assert property (take && instr_word[31:15] == 17'h02000
    |-> ##3 xfer_pulse && xfer_addr == $past(instr_word[14:0], 3))
    else $error("branch missing");
  chk_xjump_we: assert property (take && instr_word[31:29] == 3'd1
    && !instr_word[20] |-> ##3 idx_we && idx_wsel == $past(instr_word[17:15], 3))
    else $error("index not updated");
  chk_imm_nomem: assert property (take && instr_word[31:29] == 3'd2
    && instr_word[20:18] == 3'b010 |=> !mem_req [*3])
    else $error("immediate fetched");
  chk_imm_half: assert property (take && instr_word[19] && instr_word[18]
    |-> ##[1:3] illegal)
    else $error("bad mode accepted");
  chk_halt_hold: assert property (halted |-> !instr_ready && !xfer_pulse)
    else $error("activity while halted");
endmodule

// [testbench/fba_mem_model.sv]
/*
  Memory and index file model.
  Assumes one request at a time; lat delays the answer.
*/
`timescale 1ns/100ps

module fba_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic [14:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic [2:0] idx_rsel,
  output logic [15:0] idx_rdata,
  input wire logic idx_we,
  input wire logic [2:0] idx_wsel,
  input wire logic [15:0] idx_wdata
);
  logic [31:0] mem_q [0:32767];
  logic [15:0] idx_q [0:7] = '{default: 16'h0000};
  logic [31:0] data_q;
  logic [3:0] cnt_q;
  logic done_q;
  // idle bus shows the inverse word
  assign mem_rdata = mem_ack ? data_q : ~data_q;
  assign idx_rdata = idx_q[idx_rsel];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mem_ack, done_q, cnt_q, data_q} <= '0;
    end else begin
      mem_ack <= 1'b0;
      if (!mem_req) begin
        {done_q, cnt_q} <= '0;
      end else if (!done_q && cnt_q >= lat) begin
        mem_ack <= 1'b1;
        data_q <= mem_q[mem_addr];
        done_q <= 1'b1;
      end else if (!done_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
  always @(posedge pclk) begin
    if (idx_we) idx_q[idx_wsel] <= idx_wdata;
  end
endmodule

// [testbench/flag_branch_addr_modes_tb.sv]
/*
  Self-checking bench for the core.
  Assumes the memory model and checker beside it.
*/
`timescale 1ns/100ps
`include "fba_params.svh"

module flag_branch_addr_modes_tb;
  import fba_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, er, t;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, instr_word, mem_rdata, operand_data, od, rd;
  logic pready, pslverr, instr_valid, instr_ready, mem_req, mem_ack, idx_we;
  logic [14:0] instr_pc, mem_addr, xfer_addr, link_addr, exec_addr, eff_addr;
  logic [14:0] ax, al, ae;
  logic [2:0] idx_rsel, idx_wsel;
  logic [15:0] idx_rdata, idx_wdata, flags, fm;
  logic arith_done, acc_zero, acc_pos, acc_neg, arith_ovf, arith_carry;
  logic chan_busy, int_mode, xfer_pulse, link_pulse, exec_pulse, halted;
  logic operand_valid, store_req, illegal, sx, sl, se, so, sm, ss;
  logic [3:0] lat = 4'd0;
  int n_mismatch = 0;
  int tests_run = 0;

  fba_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .instr_ready(instr_ready), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .idx_rsel(idx_rsel), .idx_rdata(idx_rdata), .idx_we(idx_we),
    .idx_wsel(idx_wsel), .idx_wdata(idx_wdata), .arith_done(arith_done),
    .acc_zero(acc_zero), .acc_pos(acc_pos), .acc_neg(acc_neg),
    .arith_ovf(arith_ovf), .arith_carry(arith_carry),
    .chan_busy(chan_busy), .int_mode(int_mode), .xfer_pulse(xfer_pulse),
    .xfer_addr(xfer_addr), .link_pulse(link_pulse), .link_addr(link_addr),
    .exec_pulse(exec_pulse), .exec_addr(exec_addr), .halted(halted),
    .operand_valid(operand_valid), .operand_data(operand_data),
    .store_req(store_req), .eff_addr(eff_addr), .illegal(illegal),
    .flags(flags));
  fba_mem_model u_mem (.pclk(pclk), .presetn(presetn), .lat(lat),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .idx_rsel(idx_rsel), .idx_rdata(idx_rdata),
    .idx_we(idx_we), .idx_wsel(idx_wsel), .idx_wdata(idx_wdata));

  always #10 pclk = ~pclk;

  // one-cycle pulses caught mid-cycle
  always @(negedge pclk) begin
    if (xfer_pulse) {sx, ax} = {1'b1, xfer_addr};
    if (link_pulse) {sl, al} = {1'b1, link_addr};
    if (exec_pulse) {se, ae} = {1'b1, exec_addr};
    if (operand_valid) {so, od} = {1'b1, operand_data};
    if (mem_req) sm = 1'b1;
    if (store_req) ss = 1'b1;
  end

  function automatic logic [31:0] iw(input logic [2:0] c, s,
    input logic v, input logic [3:0] f, input logic d, m, h,
    input logic [2:0] x, input logic [14:0] a);
    return {c, s, v, f, d, m, h, x, a};
  endfunction

  task automatic chk(input logic [63:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask

  task automatic run(input logic [31:0] w);
    {sx, sl, se, so, sm, ss} = 6'b0;
    @(posedge pclk);
    {instr_valid, instr_word, instr_pc} <= {1'b1, w, 15'h0040};
    @(negedge pclk);
    while (instr_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    instr_valid <= 1'b0;
    @(negedge pclk);
    while (instr_ready !== 1'b1 && halted !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic arith(input logic [4:0] v);
    @(posedge pclk);
    {arith_done, acc_zero, acc_pos, acc_neg, arith_ovf, arith_carry} <= {1'b1, v};
    @(posedge pclk);
    arith_done <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic t_regs();
    chk(flags, `FBA_FLAGS_RST);
    apb(1'b1, `FBA_OFS_FLAGS, 32'h0000FFFF);
    chk(flags, 16'hFF3F);
    @(posedge pclk);
    {chan_busy, int_mode} <= 2'b11;
    repeat (2) @(negedge pclk);
    chk(flags[7:6], 2'b11);
    @(posedge pclk);
    {chan_busy, int_mode} <= 2'b00;
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    arith(5'b10010);
    chk(flags[5:1], 5'b01001);
    arith(5'b00100);
    chk(flags[5:1], 5'b01100);
    apb(1'b1, `FBA_OFS_FLAGS, 32'h00005A2B);
    fm = 16'h5A2B;
    chk(flags, fm);
  endtask

  task automatic t_flags();
    for (int f = 0; f < 16; f++) begin
      for (int i = 0; i < 2; i++) begin
        run(iw(FBA_CLS_FLAG, cond_branch, i[0], f[3:0], 0, 0, 0, 0, 15'h0100));
        chk(sx, fm[f] ^ i[0]);
      end
    end
    chk(ax, 15'h0100);
    for (int k = 2; k < 8; k++) begin
      for (int f = 12; f < 14; f++) begin
        t = fm[f];
        run(iw(FBA_CLS_FLAG, k[2:0], 0, f[3:0], 0, 0, 0, 0, 15'h0222));
        if (k[0] || k > 4) fm[f] = (k == 6) | ((k == 7) & ~t);
        chk(sx, t);
        chk(sl, t & (k < 4));
        chk(flags, fm);
      end
    end
    chk(al, 15'h0041);
    run(iw(FBA_CLS_FLAG, remote_execute, 0, 4'd11, 0, 0, 0, 0, 15'h0333));
    chk({se, sx, ae}, {2'b10, 15'h0333});
    run(iw(FBA_CLS_FLAG, remote_execute, 0, 4'd10, 0, 0, 0, 0, 15'h0333));
    chk(se, 1'b0);
    run(iw(FBA_CLS_FLAG, halt_then_branch, 0, 4'd0, 0, 0, 0, 0, 15'h0444));
    chk({halted, sx}, 2'b10);
    apb(1'b1, `FBA_OFS_CTRL, 32'h1);
    repeat (2) @(negedge pclk);
    chk({halted, sx, ax}, {2'b01, 15'h0444});
  endtask

  task automatic t_addr();
    u_mem.idx_q[2] = 16'h0005;
    run(iw(FBA_CLS_XJUMP, 0, 0, 4'hF, 0, 0, 0, 3'd2, 15'h0555));
    chk({sx, u_mem.idx_q[2]}, {1'b1, 16'h0004});
    run(iw(FBA_CLS_XJUMP, 0, 0, 4'h3, 0, 0, 0, 3'd2, 15'h0555));
    chk({sx, u_mem.idx_q[2]}, {1'b0, 16'h0007});
    u_mem.idx_q[3] = 16'h0010;
    u_mem.mem_q[15'h0110] = 32'hCAFE1234;
    run(iw(FBA_CLS_OP32, 0, 0, 0, 0, 0, 0, 3'd3, 15'h0100));
    chk({od, eff_addr}, {32'hCAFE1234, 15'h0110});
    for (int h = 0; h < 2; h++) begin
      run(iw(FBA_CLS_OP16, 0, 0, 0, 0, 0, h[0], 3'd3, 15'h0100));
      chk(od, h ? 32'h1234 : 32'hCAFE);
      chk(eff_addr, 15'h0110);
    end
    lat = 4'd3;
    u_mem.mem_q[15'h0200] = {17'h0, 15'h0500};
    u_mem.mem_q[15'h0210] = {11'h0, 1'b1, 2'b0, 3'd3, 15'h0300};
    u_mem.mem_q[15'h0310] = {17'h0, 15'h0400};
    u_mem.mem_q[15'h0400] = 32'h13579BDF;
    run(iw(FBA_CLS_OP32, 0, 0, 0, 1'b1, 0, 0, 3'd3, 15'h0200));
    chk({od, eff_addr}, {32'h13579BDF, 15'h0400});
    u_mem.mem_q[15'h0100] = 32'h00100000;
    run(iw(FBA_CLS_INDEX, 0, 0, 0, 0, 0, 0, 3'd3, 15'h0100));
    chk(eff_addr, 15'h0100);
    run(iw(FBA_CLS_OP16, 0, 0, 0, 0, 1'b1, 0, 3'd3, 15'h0123));
    chk({so, sm, od}, {2'b10, 32'h00000133});
    run(iw(FBA_CLS_STORE16, 0, 0, 0, 0, 0, 0, 0, 15'h0123));
    chk({ss, so, eff_addr}, {2'b10, 15'h0123});
    for (int k = 2; k < 5; k++) begin
      run(iw(k[2:0], 0, 0, 0, 0, 1'b1, k == 2, 0, 15'h0123));
      apb(1'b0, `FBA_OFS_STATUS, 32'h0);
      chk({so, ss, rd[1]}, 3'b001);
      apb(1'b1, `FBA_OFS_CTRL, 32'h2);
      chk(illegal, 1'b0);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, instr_valid, arith_done, chan_busy} = '0;
    {acc_zero, acc_pos, acc_neg, arith_ovf, arith_carry, int_mode} = '0;
    {paddr, pwdata, instr_word, instr_pc} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_regs();
    t_flags();
    t_addr();
    complete_run();
  end

  // a few hundred cycles needed; ample margin
  initial begin
    #1000000;
    n_mismatch++;
    complete_run();
  end
endmodule

bind fba_core fba_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite),
  .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .mem_req(mem_req), .idx_we(idx_we),
  .idx_wsel(idx_wsel), .arith_done(arith_done), .acc_zero(acc_zero),
  .acc_neg(acc_neg), .arith_ovf(arith_ovf), .chan_busy(chan_busy),
  .xfer_pulse(xfer_pulse), .xfer_addr(xfer_addr),
  .link_pulse(link_pulse), .halted(halted), .illegal(illegal),
  .flags(flags));
